// ### rtl/srp_defines.svh
// Serial addresses, field positions, reset values and fixed counts of the reference pulse controller
`ifndef SRP_DEFINES_SVH
`define SRP_DEFINES_SVH

// ----------------------------------------
// Frame layout
// ----------------------------------------
`define SRP_FRAME_BITS 5'h18
`define SRP_HEADER_BITS 5'h08
`define SRP_RW_BIT 23
`define SRP_ADDR_LSB 16
`define SRP_READ_FLAG 1'h1

// ----------------------------------------
// Register addresses
// ----------------------------------------
`define SRP_ADDR_MODE 7'h00
`define SRP_ADDR_OUTSEL 7'h01
`define SRP_ADDR_REFCFG 7'h02
`define SRP_ADDR_REFDIV 7'h03
`define SRP_ADDR_DLY01 7'h04
`define SRP_ADDR_DLY23 7'h05
`define SRP_ADDR_STATUS 7'h06

// ----------------------------------------
// Field positions
// ----------------------------------------
`define SRP_MODE_PD_BIT 0
`define SRP_MODE_RESET_BIT 1
`define SRP_MODE_CAL_BIT 3
`define SRP_MODE_SYNC_BIT 14
`define SRP_OUTSEL_SEL_LSB 0
`define SRP_OUTSEL_FMT_BIT 2
`define SRP_REFCFG_EN_BIT 0
`define SRP_REFCFG_REPEAT_BIT 1
`define SRP_REFCFG_PULSED_BIT 2
`define SRP_REFCFG_PRE_LSB 5
`define SRP_REFCFG_BURST_LSB 8
`define SRP_DLY_LO_LSB 0
`define SRP_DLY_HI_LSB 8

// ----------------------------------------
// Reset values and fixed codes
// ----------------------------------------
`define SRP_RST_BURST 4'h4
`define SRP_RST_DIV 11'h000
`define SRP_RST_PRE 3'h1
`define SRP_RST_SEL 2'h0
`define SRP_RST_W0 6'h24
`define SRP_RST_W1 6'h1B
`define SRP_RST_W23 6'h00
`define SRP_SEL_REF_PULSE 2'h2
`define SRP_PRE_DIV1 3'h1
`define SRP_PRE_DIV2 3'h2
`define SRP_PRE_DIV4 3'h4
`define SRP_RATE_DIV_MIN 11'h0AA
`define SRP_DELAY_SUM 8'h3F

`endif

// ### rtl/srp_pkg.sv
// Types shared by the reference pulse controller modules
package srp_pkg;

  // Configuration held by the serial registers
  typedef struct packed {
    logic phaseSyncModeEnable;
    logic powerDownBit;
    logic resetBit;
    logic [1:0] auxOutputSelect;
    logic inputPinFormat;
    logic refPulseEnable;
    logic refRepeatSelect;
    logic refPulsedSelect;
    logic [2:0] refPreDivider;
    logic [3:0] refBurstLength;
    logic [10:0] refRateDivider;
    logic [5:0] delayWeight0;
    logic [5:0] delayWeight1;
    logic [5:0] delayWeight2;
    logic [5:0] delayWeight3;
  } srp_cfg_t;

  // Register write decoded from a finished frame
  typedef struct packed {
    logic valid;
    logic [6:0] addr;
    logic [15:0] data;
  } srp_wr_t;

  // Output pulse sequencer
  typedef enum logic [1:0] {
    SRP_IDLE = 2'b00,
    SRP_HIGH = 2'b01,
    SRP_LOW = 2'b11,
    SRP_DONE = 2'b10
  } srp_fsm_t;

endpackage

// ### rtl/srp_pulse_div.sv
// Programmable divider that turns an enable stream into one-cycle ticks
`timescale 1ns/1ps
module srp_pulse_div #(
  parameter int WIDTH = 11
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Control
  input wire logic clear,
  input wire logic enable,
  input wire logic [WIDTH-1:0] divisor,
  // Result
  output logic tick
);
  import srp_pkg::*;

  typedef struct packed {
    logic [WIDTH-1:0] count;
  } srp_div_state_t;

  srp_div_state_t st;
  srp_div_state_t next_st;

  // A divisor of zero never ticks; a shrinking divisor still wraps because of the compare
  assign tick = enable && (divisor != '0) && (st.count >= divisor - WIDTH'(1));

  always_comb
  begin
    next_st = st;
    if (clear)
    begin
      next_st.count = '0;
    end
    else if (enable)
    begin
      next_st.count = tick ? '0 : st.count + WIDTH'(1);
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

endmodule // srp_pulse_div

// ### rtl/srp_serial_port.sv
// Serial programming port: 24-bit frames, write on chip select release, readback on sdo
`timescale 1ns/1ps
`include "srp_defines.svh"
module srp_serial_port (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Serial pins
  input wire logic serialClock,
  input wire logic serialDataIn,
  input wire logic chipSelectN,
  output logic serialDataOut,
  // Register side
  input wire logic [15:0] readData,
  output logic [6:0] readAddr,
  output srp_pkg::srp_wr_t wr
);
  import srp_pkg::*;

  typedef struct packed {
    logic clkPrev;
    logic csPrev;
    logic [23:0] shift;
    logic [4:0] count;
    logic [15:0] rdShift;
    logic rdMode;
    logic sdo;
    srp_wr_t wr;
  } srp_sp_state_t;

  srp_sp_state_t st;
  srp_sp_state_t next_st;
  logic clkRise;
  logic clkFall;
  logic csRise;

  assign clkRise = serialClock && !st.clkPrev;
  assign clkFall = !serialClock && st.clkPrev;
  assign csRise = chipSelectN && !st.csPrev;
  assign readAddr = st.shift[6:0];
  assign serialDataOut = st.sdo;
  assign wr = st.wr;

  always_comb
  begin
    next_st = st;
    next_st.clkPrev = serialClock;
    next_st.csPrev = chipSelectN;
    next_st.wr.valid = 1'b0;
    if (chipSelectN)
    begin
      next_st.count = '0;
      next_st.sdo = 1'b0;
      next_st.rdMode = 1'b0;
      // Only a full-length write frame reaches a register
      if (csRise && st.count == `SRP_FRAME_BITS && !st.shift[`SRP_RW_BIT])
      begin
        next_st.wr.valid = 1'b1;
        next_st.wr.addr = st.shift[`SRP_ADDR_LSB +: 7];
        next_st.wr.data = st.shift[15:0];
      end
    end
    else
    begin
      if (clkRise && st.count != `SRP_FRAME_BITS)
      begin
        next_st.shift = {st.shift[22:0], serialDataIn};
        next_st.count = st.count + 5'h01;
      end
      // Header complete and flagged read: drive data on falling edges for the host to sample on rising
      if (clkFall && st.count == `SRP_HEADER_BITS && !st.rdMode && st.shift[7] == `SRP_READ_FLAG)
      begin
        next_st.rdMode = 1'b1;
        next_st.sdo = readData[15];
        next_st.rdShift = {readData[14:0], 1'b0};
      end
      // The flag is latched because later data bits push it out of the header position
      else if (clkFall && st.rdMode)
      begin
        next_st.sdo = st.rdShift[15];
        next_st.rdShift = {st.rdShift[14:0], 1'b0};
      end
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      // Chip select idles high, so its history starts high to avoid a false release edge
      st <= '{csPrev: 1'b1, default: '0};
    end
    else
    begin
      st <= next_st;
    end
  end

  a_frame_write: assert property (@(posedge clk) disable iff (reset)
    (csRise && st.count == `SRP_FRAME_BITS && !st.shift[`SRP_RW_BIT])
    |=> (wr.valid && wr.data == $past(st.shift[15:0])))
    else $error("complete write frame not delivered");
  a_bit_shift: assert property (@(posedge clk) disable iff (reset)
    (!chipSelectN && clkRise && st.count < `SRP_FRAME_BITS) |=> (st.shift[0] == $past(serialDataIn)))
    else $error("serial bit not shifted in");
  a_read_nowrite: assert property (@(posedge clk) disable iff (reset)
    (csRise && st.shift[`SRP_RW_BIT]) |=> !wr.valid)
    else $error("read frame caused a write");

endmodule // srp_serial_port

// ### rtl/srp_ctrl.sv
// Reference pulse controller: serial configuration, generator and repeater pulse sequencing
// ----------------------------------------
// ----------------------------------------
`timescale 1ns/1ps
`include "srp_defines.svh"
module srp_ctrl (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Serial programming port
  input wire logic serialClock,
  input wire logic serialDataIn,
  input wire logic chipSelectN,
  output logic serialDataOut,
  // Device pins
  input wire logic chipEnable,
  input wire logic refRequestPin,
  output logic auxRfOutput,
  // Status and configuration seen by the analog side
  output logic power_down_bit,
  output logic freqCalStart,
  output logic inputPinFormat,
  output logic refModeActive,
  output logic configError,
  output srp_pkg::srp_cfg_t cfgOut
);
  import srp_pkg::*;

  typedef struct packed {
    srp_cfg_t cfg;
    srp_fsm_t fsm;
    logic [3:0] pulses;
    logic aux;
    logic reqInterp;
    logic reqMain;
    logic reqPrev;
    logic calStart;
    logic pd;
    logic active;
    logic pinFmt;
    logic err;
  } srp_ctrl_state_t;

  srp_ctrl_state_t st;
  srp_ctrl_state_t next_st;
  srp_wr_t wr;
  logic [6:0] readAddr;
  logic [15:0] readData;
  logic interpTick;
  logic rateTick;
  logic preValid;
  logic softReset;
  logic pdNow;
  logic modeActive;
  logic reqRise;
  logic genAbort;
  logic [7:0] weightSum;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic srp_cfg_t resetCfg(input logic pdBit, input logic rstBit);
    srp_cfg_t c;
    c = '0;
    c.powerDownBit = pdBit;
    c.resetBit = rstBit;
    c.auxOutputSelect = `SRP_RST_SEL;
    c.refPreDivider = `SRP_RST_PRE;
    c.refBurstLength = `SRP_RST_BURST;
    c.refRateDivider = `SRP_RST_DIV;
    c.delayWeight0 = `SRP_RST_W0;
    c.delayWeight1 = `SRP_RST_W1;
    c.delayWeight2 = `SRP_RST_W23;
    c.delayWeight3 = `SRP_RST_W23;
    return c;
  endfunction

  // A burst of zero pulses finishes at once
  function automatic srp_fsm_t startState(input srp_cfg_t c);
    return (c.refPulsedSelect && c.refBurstLength == 4'h0) ? SRP_DONE : SRP_HIGH;
  endfunction

  function automatic logic [15:0] readReg(input logic [6:0] a, input srp_ctrl_state_t s);
    logic [15:0] d;
    d = 16'h0000;
    unique case (a)
      `SRP_ADDR_MODE:
      begin
        d[`SRP_MODE_PD_BIT] = s.cfg.powerDownBit;
        d[`SRP_MODE_RESET_BIT] = s.cfg.resetBit;
        d[`SRP_MODE_SYNC_BIT] = s.cfg.phaseSyncModeEnable;
      end
      `SRP_ADDR_OUTSEL:
      begin
        d[`SRP_OUTSEL_SEL_LSB +: 2] = s.cfg.auxOutputSelect;
        d[`SRP_OUTSEL_FMT_BIT] = s.cfg.inputPinFormat;
      end
      `SRP_ADDR_REFCFG:
      begin
        d[`SRP_REFCFG_EN_BIT] = s.cfg.refPulseEnable;
        d[`SRP_REFCFG_REPEAT_BIT] = s.cfg.refRepeatSelect;
        d[`SRP_REFCFG_PULSED_BIT] = s.cfg.refPulsedSelect;
        d[`SRP_REFCFG_PRE_LSB +: 3] = s.cfg.refPreDivider;
        d[`SRP_REFCFG_BURST_LSB +: 4] = s.cfg.refBurstLength;
      end
      `SRP_ADDR_REFDIV: d[10:0] = s.cfg.refRateDivider;
      `SRP_ADDR_DLY01: d = {2'h0, s.cfg.delayWeight1, 2'h0, s.cfg.delayWeight0};
      `SRP_ADDR_DLY23: d = {2'h0, s.cfg.delayWeight3, 2'h0, s.cfg.delayWeight2};
      `SRP_ADDR_STATUS: d = {8'h00, s.pulses, s.err, s.pd, s.fsm};
      default: d = 16'h0000;
    endcase
    return d;
  endfunction

  // ----------------------------------------
  // Serial port and dividers
  // ----------------------------------------
  srp_serial_port u_port (
    .clk(clk),
    .reset(reset),
    .serialClock(serialClock),
    .serialDataIn(serialDataIn),
    .chipSelectN(chipSelectN),
    .serialDataOut(serialDataOut),
    .readData(readData),
    .readAddr(readAddr),
    .wr(wr)
  );

  assign readData = readReg(readAddr, st);

  assign preValid = st.cfg.refPreDivider == `SRP_PRE_DIV1 || st.cfg.refPreDivider == `SRP_PRE_DIV2
    || st.cfg.refPreDivider == `SRP_PRE_DIV4;

  // An invalid pre-divider code stalls the interpolator rather than guessing a ratio
  srp_pulse_div #(.WIDTH(3)) u_pre (
    .clk(clk),
    .reset(reset),
    .clear(!preValid),
    .enable(1'b1),
    .divisor(preValid ? st.cfg.refPreDivider : 3'h0),
    .tick(interpTick)
  );

  // Cleared outside a pulse train so every train starts with a full high phase
  srp_pulse_div #(.WIDTH(11)) u_rate (
    .clk(clk),
    .reset(reset),
    .clear(st.fsm == SRP_IDLE || st.fsm == SRP_DONE),
    .enable(interpTick),
    .divisor(st.cfg.refRateDivider),
    .tick(rateTick)
  );

  // ----------------------------------------
  // Mode decode
  // ----------------------------------------
  assign softReset = st.cfg.resetBit && !st.cfg.powerDownBit;
  assign pdNow = st.cfg.powerDownBit || !chipEnable;
  assign modeActive = st.cfg.phaseSyncModeEnable && st.cfg.refPulseEnable
    && st.cfg.auxOutputSelect == `SRP_SEL_REF_PULSE && !pdNow && !softReset;
  assign reqRise = st.reqMain && !st.reqPrev;
  assign genAbort = !st.cfg.refRepeatSelect && !refRequestPin;
  assign weightSum = 8'(st.cfg.delayWeight0) + 8'(st.cfg.delayWeight1) + 8'(st.cfg.delayWeight2)
    + 8'(st.cfg.delayWeight3);

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    next_st = st;
    next_st.calStart = 1'b0;
    if (wr.valid)
    begin
      unique case (wr.addr)
        `SRP_ADDR_MODE:
        begin
          next_st.cfg.powerDownBit = wr.data[`SRP_MODE_PD_BIT];
          next_st.cfg.resetBit = wr.data[`SRP_MODE_RESET_BIT];
          next_st.cfg.phaseSyncModeEnable = wr.data[`SRP_MODE_SYNC_BIT];
          next_st.calStart = wr.data[`SRP_MODE_CAL_BIT];
        end
        `SRP_ADDR_OUTSEL:
        begin
          next_st.cfg.auxOutputSelect = wr.data[`SRP_OUTSEL_SEL_LSB +: 2];
          next_st.cfg.inputPinFormat = wr.data[`SRP_OUTSEL_FMT_BIT];
        end
        `SRP_ADDR_REFCFG:
        begin
          next_st.cfg.refPulseEnable = wr.data[`SRP_REFCFG_EN_BIT];
          next_st.cfg.refRepeatSelect = wr.data[`SRP_REFCFG_REPEAT_BIT];
          next_st.cfg.refPulsedSelect = wr.data[`SRP_REFCFG_PULSED_BIT];
          next_st.cfg.refPreDivider = wr.data[`SRP_REFCFG_PRE_LSB +: 3];
          next_st.cfg.refBurstLength = wr.data[`SRP_REFCFG_BURST_LSB +: 4];
        end
        `SRP_ADDR_REFDIV: next_st.cfg.refRateDivider = wr.data[10:0];
        `SRP_ADDR_DLY01:
        begin
          next_st.cfg.delayWeight0 = wr.data[`SRP_DLY_LO_LSB +: 6];
          next_st.cfg.delayWeight1 = wr.data[`SRP_DLY_HI_LSB +: 6];
        end
        `SRP_ADDR_DLY23:
        begin
          next_st.cfg.delayWeight2 = wr.data[`SRP_DLY_LO_LSB +: 6];
          next_st.cfg.delayWeight3 = wr.data[`SRP_DLY_HI_LSB +: 6];
        end
        default:
        begin
          next_st.cfg = next_st.cfg;
        end
      endcase
    end
    // Power-down and reset bits stay writable under soft reset, otherwise it could never be released
    if (softReset)
    begin
      next_st.cfg = resetCfg(next_st.cfg.powerDownBit, next_st.cfg.resetBit);
      next_st.calStart = 1'b0;
    end

    // Two-stage re-time: interpolator rate first, then the main output clock
    if (interpTick)
    begin
      next_st.reqInterp = refRequestPin;
    end
    next_st.reqMain = st.reqInterp;
    next_st.reqPrev = st.reqMain;

    if (!modeActive)
    begin
      next_st.fsm = SRP_IDLE;
      next_st.pulses = 4'h0;
    end
    else
    begin
      unique case (st.fsm)
        SRP_IDLE:
        begin
          if ((!st.cfg.refRepeatSelect && refRequestPin) || (st.cfg.refRepeatSelect && reqRise))
          begin
            next_st.fsm = startState(st.cfg);
            next_st.pulses = 4'h0;
          end
        end
        SRP_HIGH:
        begin
          if (genAbort)
          begin
            next_st.fsm = SRP_IDLE;
          end
          else if (rateTick)
          begin
            next_st.fsm = SRP_LOW;
          end
        end
        SRP_LOW:
        begin
          if (genAbort)
          begin
            next_st.fsm = SRP_IDLE;
          end
          else if (rateTick)
          begin
            next_st.pulses = st.pulses + 4'h1;
            // Pulsed mode stops after the programmed count; continuous mode always returns to the high phase here
            if (st.cfg.refPulsedSelect && st.pulses + 4'h1 >= st.cfg.refBurstLength)
            begin
              next_st.fsm = SRP_DONE;
            end
            else
            begin
              next_st.fsm = SRP_HIGH;
            end
          end
        end
        SRP_DONE:
        begin
          if (genAbort)
          begin
            next_st.fsm = SRP_IDLE;
          end
          else if (st.cfg.refRepeatSelect && reqRise)
          begin
            next_st.fsm = startState(st.cfg);
            next_st.pulses = 4'h0;
          end
        end
      endcase
    end
    next_st.aux = next_st.fsm == SRP_HIGH;
    next_st.pd = pdNow;
    next_st.active = modeActive;
    // LVDS is refused in generator mode by falling back to CMOS
    next_st.pinFmt = next_st.cfg.inputPinFormat && next_st.cfg.refRepeatSelect;
    next_st.err = (st.cfg.refPulseEnable != (st.cfg.auxOutputSelect == `SRP_SEL_REF_PULSE))
      || (st.cfg.refPulseEnable && (!preValid || st.cfg.refRateDivider < `SRP_RATE_DIV_MIN))
      || weightSum != `SRP_DELAY_SUM;
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      st <= '{cfg: resetCfg(1'b0, 1'b0), fsm: SRP_IDLE, default: '0};
    end
    else
    begin
      st <= next_st;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign auxRfOutput = st.aux;
  assign power_down_bit = st.pd;
  assign freqCalStart = st.calStart;
  assign inputPinFormat = st.pinFmt;
  assign refModeActive = st.active;
  assign configError = st.err;
  assign cfgOut = st.cfg;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  a_pd_quiet: assert property (pdNow |=> (!auxRfOutput && power_down_bit))
    else $error("output active while powered down");
  a_mode_gate: assert property (!modeActive |=> (st.fsm == SRP_IDLE && !auxRfOutput))
    else $error("pulses without reference mode");
  a_soft_reset: assert property (softReset |=> (st.cfg.refBurstLength == `SRP_RST_BURST
    && !st.cfg.refPulseEnable && !st.cfg.refRepeatSelect && st.cfg.refRateDivider == `SRP_RST_DIV))
    else $error("soft reset did not restore fields");
  a_pre_invalid: assert property (!preValid |-> !interpTick)
    else $error("interpolator runs on invalid code");
  a_gen_request: assert property ((modeActive && genAbort && st.fsm != SRP_IDLE) |=> st.fsm == SRP_IDLE)
    else $error("generator kept running without request");
  a_burst_bound: assert property ((st.fsm != SRP_IDLE && st.cfg.refPulsedSelect) |->
    (st.pulses <= st.cfg.refBurstLength))
    else $error("burst exceeded programmed length");
  a_rep_start: assert property ((modeActive && st.cfg.refRepeatSelect && reqRise && st.fsm == SRP_IDLE)
    |=> st.fsm == startState($past(st.cfg)))
    else $error("repeater missed a request edge");
  a_retime_path: assert property ((interpTick && modeActive) |=> ##1 st.reqMain == $past(refRequestPin, 2))
    else $error("request not re-timed in two stages");
  a_lvds_gen: assert property (inputPinFormat |-> st.cfg.refRepeatSelect)
    else $error("LVDS format in generator mode");
  a_cal_pulse: assert property ((wr.valid && wr.addr == `SRP_ADDR_MODE && wr.data[`SRP_MODE_CAL_BIT]
    && !softReset) |=> freqCalStart ##1 !freqCalStart)
    else $error("calibration start not pulsed");
  a_zero_burst: assert property ((modeActive && st.fsm == SRP_IDLE && st.cfg.refPulsedSelect
    && st.cfg.refBurstLength == 4'h0 && !st.cfg.refRepeatSelect && refRequestPin) |=> st.fsm == SRP_DONE)
    else $error("zero burst length mishandled");

endmodule // srp_ctrl

// ### verification/srp_host.sv
// Host controller model driving the serial programming port
`timescale 1ns/1ps
module srp_host (
  // Clock
  input wire logic clk,
  // Serial pins
  output logic serialClock,
  output logic serialDataIn,
  output logic chipSelectN,
  input wire logic serialDataOut
);
  initial
  begin
    serialClock = 1'b0;
    serialDataIn = 1'b0;
    chipSelectN = 1'b1;
  end
  // Sends n bits MSB first; a count below 24 makes a frame the device must drop
  task automatic xfer(input logic [23:0] f, input int n, output logic [15:0] rd);
    rd = 16'h0000;
    @(negedge clk);
    chipSelectN = 1'b0;
    for (int i = 0; i < n; i++)
    begin
      serialDataIn = f[23 - i];
      repeat (3) @(negedge clk);
      if (i >= 8) rd = {rd[14:0], serialDataOut};
      serialClock = 1'b1;
      repeat (3) @(negedge clk);
      serialClock = 1'b0;
    end
    repeat (2) @(negedge clk);
    chipSelectN = 1'b1;
    // Released data line must not keep showing the last bit
    serialDataIn = ~serialDataIn;
    repeat (4) @(negedge clk);
  endtask
endmodule // srp_host

// ### verification/srp_ctrl_tb.sv
// Self-checking bench of the reference pulse controller
`timescale 1ns/1ps
`include "srp_defines.svh"
module srp_ctrl_tb;
  import srp_pkg::*;
  logic clk, reset, chipEnable, refRequestPin, serialClock, serialDataIn, chipSelectN, serialDataOut;
  logic auxRfOutput, power_down_bit, freqCalStart, inputPinFormat, refModeActive, configError, prevAux;
  srp_cfg_t cfgOut;
  logic [15:0] rd;
  int failures, numChecks, cycles, rises, highs, cals, r0, h0, c0;
  srp_ctrl srp_ctrl_inst (.clk(clk), .reset(reset), .serialClock(serialClock), .serialDataIn(serialDataIn),
    .chipSelectN(chipSelectN), .serialDataOut(serialDataOut), .chipEnable(chipEnable),
    .refRequestPin(refRequestPin), .auxRfOutput(auxRfOutput), .power_down_bit(power_down_bit),
    .freqCalStart(freqCalStart), .inputPinFormat(inputPinFormat), .refModeActive(refModeActive),
    .configError(configError), .cfgOut(cfgOut));
  srp_host srp_host_inst (.clk(clk), .serialClock(serialClock), .serialDataIn(serialDataIn),
    .chipSelectN(chipSelectN), .serialDataOut(serialDataOut));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Pulse, width and calibration counters; sampled mid-cycle where outputs are settled
  always @(negedge clk)
  begin
    cycles++;
    if (auxRfOutput === 1'b1) highs++;
    if (auxRfOutput === 1'b1 && prevAux !== 1'b1) rises++;
    if (freqCalStart === 1'b1) cals++;
    prevAux = auxRfOutput;
    if (cycles == 20000)
    begin
      failures++;
      endSim();
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    numChecks++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    srp_host_inst.xfer({1'b0, a, d}, 24, rd);
  endtask
  task automatic mark();
    r0 = rises;
    h0 = highs;
  endtask
  task automatic endSim();
    $display("checks %0d, failures %0d", numChecks, failures);
    if (failures == 0 && numChecks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial
  begin
    reset = 1'b1;
    chipEnable = 1'b1;
    refRequestPin = 1'b0;
    repeat (3) @(negedge clk);
    reset = 1'b0;
    @(negedge clk);
    check(16'(cfgOut.refBurstLength), 16'h0004);
    check(16'(cfgOut.refRateDivider), 16'h0000);
    check(16'({cfgOut.refPulseEnable, cfgOut.refRepeatSelect, cfgOut.refPulsedSelect}), 16'h0000);
    wr(`SRP_ADDR_MODE, 16'h0002);
    wr(`SRP_ADDR_MODE, 16'h0000);
    wr(`SRP_ADDR_REFDIV, 16'h07FF);
    check(16'(cfgOut.refRateDivider), 16'h07FF);
    srp_host_inst.xfer({1'b0, `SRP_ADDR_REFDIV, 16'h0002}, 23, rd);
    check(16'(cfgOut.refRateDivider), 16'h07FF);
    srp_host_inst.xfer({1'b1, `SRP_ADDR_REFDIV, 16'hA5A5}, 24, rd);
    check(rd, 16'h07FF);
    check(16'(cfgOut.refRateDivider), 16'h07FF);
    wr(`SRP_ADDR_REFDIV, 16'h0002);
    wr(`SRP_ADDR_REFCFG, 16'h0225);
    wr(`SRP_ADDR_OUTSEL, 16'h0006);
    check(16'(inputPinFormat), 16'h0000);
    // A short rate divider keeps runs brief; the status flags it as out of range
    check(16'(configError), 16'h0001);
    c0 = cals;
    wr(`SRP_ADDR_MODE, 16'h4008);
    check(16'(cals - c0), 16'h0001);
    check(16'(refModeActive), 16'h0001);
    mark();
    repeat (40) @(negedge clk);
    check(16'(rises - r0), 16'h0000);
    refRequestPin = 1'b1;
    repeat (60) @(negedge clk);
    check(16'(rises - r0), 16'h0002);
    check(16'(highs - h0), 16'h0004);
    wr(`SRP_ADDR_REFCFG, 16'h0221);
    refRequestPin = 1'b0;
    repeat (3) @(negedge clk);
    mark();
    refRequestPin = 1'b1;
    repeat (40) @(negedge clk);
    check(16'(rises - r0 > 8), 16'h0001);
    refRequestPin = 1'b0;
    wr(`SRP_ADDR_REFCFG, 16'h0247);
    check(16'(inputPinFormat), 16'h0001);
    repeat (60) @(negedge clk);
    mark();
    refRequestPin = 1'b1;
    repeat (80) @(negedge clk);
    check(16'(rises - r0), 16'h0002);
    check(16'(highs - h0), 16'h0008);
    wr(`SRP_ADDR_MODE, 16'h0002);
    check(16'({cfgOut.refBurstLength, cfgOut.refPulseEnable, refModeActive}), 16'h0010);
    wr(`SRP_ADDR_MODE, 16'h0001);
    check(16'(power_down_bit), 16'h0001);
    // Weights go high address first and keep their sum at 63; the mode register comes last
    wr(`SRP_ADDR_DLY23, 16'h0000);
    wr(`SRP_ADDR_DLY01, 16'h013E);
    srp_host_inst.xfer({1'b1, `SRP_ADDR_DLY01, 16'h0000}, 24, rd);
    check(rd, 16'h013E);
    check(16'(configError), 16'h0000);
    wr(`SRP_ADDR_MODE, 16'h0000);
    check(16'(power_down_bit), 16'h0000);
    chipEnable = 1'b0;
    repeat (2) @(negedge clk);
    check(16'(power_down_bit), 16'h0001);
    endSim();
  end
endmodule // srp_ctrl_tb
